// ### pkg/ssr_pkg.sv
// Package for the status flags and stack pointer register block.
// Assumes a single system clock and a core that issues one I/O or stack operation per cycle.
package ssr_pkg;
	localparam int          SSR_IO_AW         = 6;
	localparam int          SSR_DATA_AW       = 11;
	localparam int          SSR_SP_W          = 11;
	localparam logic [7:0]  SSR_SRAM_OFFSET   = 8'h20;
	localparam logic [5:0]  SSR_BIT_IO_MAX    = 6'h1F;
	localparam logic [5:0]  SSR_OFS_SP_LOW    = 6'h3D;
	localparam logic [5:0]  SSR_OFS_SP_HIGH   = 6'h3E;
	localparam logic [5:0]  SSR_OFS_STATUS    = 6'h3F;
	localparam logic [7:0]  SSR_SP_LOW_RST    = 8'h00;
	localparam logic [7:0]  SSR_SP_HIGH_RST   = 8'h00;
	localparam logic [7:0]  SSR_STATUS_RST    = 8'h00;
	localparam logic [7:0]  SSR_SP_HIGH_MASK  = 8'h07;
	localparam int          SSR_BIT_IE        = 7;
	localparam int          SSR_BIT_COPY      = 6;
	localparam int          SSR_BIT_HALF      = 5;
	localparam int          SSR_BIT_SIGN      = 4;
	localparam int          SSR_BIT_OVF       = 3;
	localparam int          SSR_BIT_NEG       = 2;
	localparam int          SSR_BIT_ZERO      = 1;
	localparam int          SSR_BIT_CARRY     = 0;
	localparam logic [10:0] SSR_SP_ONE        = 11'h001;
	localparam logic [10:0] SSR_SP_TWO        = 11'h002;

	typedef enum logic [2:0] {
		SSR_STK_NONE  = 3'b000,
		SSR_STK_PUSH  = 3'b001,
		SSR_STK_POP   = 3'b010,
		SSR_STK_CALL  = 3'b011,
		SSR_STK_RET   = 3'b100,
		SSR_STK_IRQ   = 3'b101,
		SSR_STK_INTERRUPT_EXIT  = 3'b110
	} ssr_stack_op_t;

	// Maps a data address onto a direct I/O address; valid only inside the I/O window
	function automatic logic [6:0] ssr_data_to_io(input logic [10:0] daddr);
		logic [10:0] rel;
		rel = daddr - {3'h0, SSR_SRAM_OFFSET};
		if (daddr >= {3'h0, SSR_SRAM_OFFSET} && rel < 11'h040)
			return {1'b1, rel[5:0]};
		return 7'h00;
	endfunction
endpackage

// ### logic/ssr_io_mux.sv
// Read multiplexer for the core registers on the I/O bus.
// Assumes the top module registers its output; peripherals outside supply ext_rdata.
`timescale 1ns/1ps
module ssr_io_mux import ssr_pkg::*; (
	input  wire logic [5:0] addr,
	input  wire logic [7:0] status_val,
	input  wire logic [7:0] sp_low_val,
	input  wire logic [7:0] sp_high_val,
	input  wire logic [7:0] ext_rdata,
	output logic      [7:0] rdata,
	output logic            is_core
);
	always_comb begin
		is_core = 1'b1;
		unique case (addr)
			SSR_OFS_STATUS:  rdata = status_val;
			SSR_OFS_SP_HIGH: rdata = sp_high_val & SSR_SP_HIGH_MASK;
			SSR_OFS_SP_LOW:  rdata = sp_low_val;
			default: begin
				rdata   = ext_rdata;
				is_core = 1'b0;
			end
		endcase
	end
endmodule // ssr_io_mux

// ### logic/ssr_core_regs.sv
// Status flags register and stack pointer with the I/O access path of the core.
// Assumes the execution unit issues at most one request per cycle and that ALU
// flag results arrive already computed; peripherals answer for other addresses.
`timescale 1ns/1ps
module ssr_core_regs import ssr_pkg::*; #(
	parameter int NUM_IRQ = 17
) (
	input  wire logic               clock,
	input  wire logic               rst_b,
	input  wire logic               io_read_op,
	input  wire logic               io_write_op,
	input  wire logic               data_space_sel,
	input  wire logic [5:0]         io_addr,
	input  wire logic [10:0]        data_addr,
	input  wire logic [7:0]         io_wdata,
	input  wire logic [7:0]         ext_rdata,
	input  wire logic               io_bit_set_op,
	input  wire logic               io_bit_clear_op,
	input  wire logic               skip_if_io_bit_set,
	input  wire logic               skip_if_io_bit_clear,
	input  wire logic [2:0]         bit_sel,
	input  wire logic               bit_to_copy_flag,
	input  wire logic               copy_flag_to_bit,
	input  wire logic [7:0]         reg_src,
	input  wire logic               alu_flags_we,
	input  wire logic [4:0]         alu_flags_mask,
	input  wire logic               alu_half,
	input  wire logic               alu_ovf,
	input  wire logic               alu_neg,
	input  wire logic               alu_zero,
	input  wire logic               alu_carry,
	input  wire logic [2:0]         stack_op,
	input  wire logic [NUM_IRQ-1:0] irq_pending,
	input  wire logic [NUM_IRQ-1:0] irq_enable,
	output logic      [7:0]         io_rdata,
	output logic                    ext_write,
	output logic      [5:0]         ext_addr,
	output logic      [7:0]         ext_wdata,
	output logic                    skip_next,
	output logic      [7:0]         reg_result,
	output logic      [7:0]         status_flags_reg,
	output logic      [10:0]        stack_ptr,
	output logic      [10:0]        stack_addr,
	output logic                    irq_request,
	output logic                    access_err
);
	typedef struct packed {
		logic [7:0]         status;
		logic [10:0]        sp;
		logic [10:0]        stk_addr;
		logic [7:0]         rdata;
		logic               ext_we;
		logic [5:0]         ext_a;
		logic [7:0]         ext_d;
		logic               skip;
		logic [7:0]         res;
		logic               irq;
		logic               err;
	} ssr_state_t;

	ssr_state_t s_q;
	ssr_state_t s_d;

	logic [6:0]  mapped;
	logic [5:0]  eff_addr;
	logic        addr_ok;
	logic [7:0]  cur_byte;
	logic        is_core;
	logic [7:0]  bit_mask;
	logic [7:0]  status_n;
	logic [7:0]  wbyte;
	logic        do_write;
	logic        bit_op;
	logic        skip_op;

	assign mapped   = ssr_data_to_io(data_addr);
	assign eff_addr = data_space_sel ? mapped[5:0] : io_addr;
	assign addr_ok  = data_space_sel ? mapped[6] : 1'b1;
	assign bit_mask = 8'h01 << bit_sel;
	assign bit_op   = io_bit_set_op | io_bit_clear_op;
	assign skip_op  = skip_if_io_bit_set | skip_if_io_bit_clear;

	ssr_io_mux u_mux (
		.addr        (eff_addr),
		.status_val  (s_q.status),
		.sp_low_val  (s_q.sp[7:0]),
		.sp_high_val ({5'h00, s_q.sp[10:8]}),
		.ext_rdata   (ext_rdata),
		.rdata       (cur_byte),
		.is_core     (is_core)
	);

	always_comb begin
		s_d          = s_q;
		s_d.ext_we   = 1'b0;
		s_d.skip     = 1'b0;
		s_d.err      = 1'b0;
		status_n     = s_q.status;
		wbyte        = io_wdata;
		do_write     = 1'b0;

		// Bit ops are a read-modify-write of the whole byte
		if (bit_op || skip_op) begin
			if (eff_addr > SSR_BIT_IO_MAX || !addr_ok) begin
				s_d.err = 1'b1;
			end else if (bit_op) begin
				wbyte    = io_bit_set_op ? (cur_byte | bit_mask) : (cur_byte & ~bit_mask);
				do_write = 1'b1;
			end else begin
				s_d.skip = skip_if_io_bit_set ? |(cur_byte & bit_mask) : ~|(cur_byte & bit_mask);
			end
		end else if (io_write_op) begin
			do_write = addr_ok;
			s_d.err  = ~addr_ok;
		end
		if (io_read_op) begin
			s_d.rdata = cur_byte;
			s_d.err   = s_d.err | ~addr_ok;
		end

		// ALU flag updates; interrupt entry and exit touch only the IE bit of status
		if (alu_flags_we) begin
			if (alu_flags_mask[4])
				status_n[SSR_BIT_HALF] = alu_half;
			if (alu_flags_mask[3])
				status_n[SSR_BIT_OVF] = alu_ovf;
			if (alu_flags_mask[2])
				status_n[SSR_BIT_NEG] = alu_neg;
			if (alu_flags_mask[1])
				status_n[SSR_BIT_ZERO] = alu_zero;
			if (alu_flags_mask[0])
				status_n[SSR_BIT_CARRY] = alu_carry;
		end
		if (bit_to_copy_flag)
			status_n[SSR_BIT_COPY] = |(reg_src & bit_mask);
		s_d.res = copy_flag_to_bit ?
			(s_q.status[SSR_BIT_COPY] ? (reg_src | bit_mask) : (reg_src & ~bit_mask)) : reg_src;

		s_d.stk_addr = s_q.sp;
		unique case (ssr_stack_op_t'(stack_op))
			SSR_STK_NONE: begin
			end
			SSR_STK_PUSH: begin
				s_d.stk_addr = s_q.sp;
				s_d.sp       = s_q.sp - SSR_SP_ONE;
			end
			SSR_STK_CALL: begin
				s_d.stk_addr = s_q.sp;
				s_d.sp       = s_q.sp - SSR_SP_TWO;
			end
			SSR_STK_IRQ: begin
				s_d.stk_addr = s_q.sp;
				s_d.sp       = s_q.sp - SSR_SP_TWO;
				status_n[SSR_BIT_IE] = 1'b0;
			end
			SSR_STK_POP: begin
				s_d.sp       = s_q.sp + SSR_SP_ONE;
				s_d.stk_addr = s_q.sp + SSR_SP_ONE;
			end
			SSR_STK_RET: begin
				s_d.sp       = s_q.sp + SSR_SP_TWO;
				s_d.stk_addr = s_q.sp + SSR_SP_ONE;
			end
			SSR_STK_INTERRUPT_EXIT: begin
				s_d.sp       = s_q.sp + SSR_SP_TWO;
				s_d.stk_addr = s_q.sp + SSR_SP_ONE;
				status_n[SSR_BIT_IE] = 1'b1;
			end
			default: begin
			end
		endcase

		// Byte writes to core registers take precedence over implicit updates other than the sign flag, which stays N xor V
		s_d.ext_a = eff_addr;
		s_d.ext_d = wbyte;
		if (do_write) begin
			unique case (eff_addr)
				SSR_OFS_STATUS:  status_n = wbyte;
				SSR_OFS_SP_HIGH: s_d.sp[10:8] = wbyte[2:0];
				SSR_OFS_SP_LOW:  s_d.sp[7:0] = wbyte;
				default:         s_d.ext_we = ~is_core;
			endcase
		end
		status_n[SSR_BIT_SIGN] = status_n[SSR_BIT_NEG] ^ status_n[SSR_BIT_OVF];
		s_d.status = status_n;

		s_d.irq = status_n[SSR_BIT_IE] & |(irq_pending & irq_enable);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign io_rdata         = s_q.rdata;
	assign ext_write        = s_q.ext_we;
	assign ext_addr         = s_q.ext_a;
	assign ext_wdata        = s_q.ext_d;
	assign skip_next        = s_q.skip;
	assign reg_result       = s_q.res;
	assign status_flags_reg = s_q.status;
	assign stack_ptr        = s_q.sp;
	assign stack_addr       = s_q.stk_addr;
	assign irq_request      = s_q.irq;
	assign access_err       = s_q.err;
endmodule // ssr_core_regs

// ### sim/ssr_periph_model.sv
// Peripheral byte store standing behind the core registers on the I/O bus.
// Assumes reads are combinational on rd_addr and writes come by ext_write.
`timescale 1ns/1ps
module ssr_periph_model (
	input  wire logic       clock,
	input  wire logic       ext_write,
	input  wire logic [5:0] ext_addr,
	input  wire logic [7:0] ext_wdata,
	input  wire logic [5:0] rd_addr,
	output logic      [7:0] ext_rdata
);
	logic [7:0] mem [64];
	// Distinct start values so a wrong address shows up
	initial for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'hA5;
	always @(posedge clock) if (ext_write) mem[ext_addr] <= ext_wdata;
	assign ext_rdata = mem[rd_addr];
endmodule // ssr_periph_model

// ### sim/ssr_props.sv
// Concurrent checks on the status flags and stack pointer block.
// Bound to the core register module; one clock domain.
`timescale 1ns/1ps
module ssr_props #(
	parameter int NUM_IRQ = 17
) (
	input wire logic               clock,
	input wire logic               rst_b,
	input wire logic               io_write_op,
	input wire logic               io_bit_set_op,
	input wire logic               data_space_sel,
	input wire logic [5:0]         io_addr,
	input wire logic [7:0]         io_wdata,
	input wire logic [2:0]         stack_op,
	input wire logic               alu_flags_we,
	input wire logic               bit_to_copy_flag,
	input wire logic [NUM_IRQ-1:0] irq_pending,
	input wire logic [NUM_IRQ-1:0] irq_enable,
	input wire logic [7:0]         status_flags_reg,
	input wire logic [10:0]        stack_ptr,
	input wire logic [10:0]        stack_addr,
	input wire logic               irq_request,
	input wire logic               access_err
);
	logic any_req;
	assign any_req = |(irq_pending & irq_enable);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence s_stk(logic [2:0] a);
		stack_op == a && !io_write_op;
	endsequence
	property p_sign; status_flags_reg[4] == (status_flags_reg[2] ^ status_flags_reg[3]); endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong");
	property p_push;
		s_stk(3'h1) |=> stack_ptr == $past(stack_ptr) - 11'h001 && stack_addr == $past(stack_ptr);
	endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_pop; s_stk(3'h2) |=> stack_ptr == $past(stack_ptr) + 11'h001 && stack_addr == stack_ptr; endproperty
	a_pop: assert property (p_pop) else $error("pop wrong");
	property p_ie_clr; s_stk(3'h5) |=> !status_flags_reg[7]; endproperty
	a_ie_clr: assert property (p_ie_clr) else $error("enable kept on entry");
	property p_ie_set; s_stk(3'h6) |=> status_flags_reg[7]; endproperty
	a_ie_set: assert property (p_ie_set) else $error("enable not set on return");
	property p_gate; 1'b1 |=> irq_request == (status_flags_reg[7] && $past(any_req)); endproperty
	a_gate: assert property (p_gate) else $error("request not gated");
	property p_sph;
		io_write_op && !data_space_sel && io_addr == 6'h3E && stack_op == 3'h0 |=> stack_ptr[10:8] == $past(io_wdata[2:0]);
	endproperty
	a_sph: assert property (p_sph) else $error("high byte write wrong");
	// Only direct I/O bit set ops with no other status update in the same cycle
	property p_bit_err;
		io_bit_set_op && !data_space_sel && io_addr > 6'h1F && stack_op == 3'h0 && !alu_flags_we && !bit_to_copy_flag
			|=> access_err && $stable(status_flags_reg);
	endproperty
	a_bit_err: assert property (p_bit_err) else $error("bit op not refused");
endmodule // ssr_props
bind ssr_core_regs ssr_props #(.NUM_IRQ(NUM_IRQ)) u_ssr_props (.*);

// ### sim/status_and_stack_regs_tb.sv
// Bench for the status flags and stack pointer block.
// Assumes the peripheral model answers reads outside the core registers.
`timescale 1ns/1ps
module status_and_stack_regs_tb;
	logic        clock = 1'b0, rst_b = 1'b0, ext_write, skip_next, irq_request, access_err;
	logic [12:0] cmd = '0;
	logic [5:0]  io_addr = '0, ext_addr;
	logic [10:0] data_addr = '0, stack_ptr, stack_addr;
	logic [7:0]  io_wdata = '0, ext_rdata, io_rdata, ext_wdata, reg_result, status_flags_reg;
	logic [16:0] irq_pending = '0, irq_enable = '0;
	int          mismatches = 0, checks = 0;
	always #2.5 clock = ~clock;
	ssr_core_regs u_ssr_core_regs (.*, .io_read_op(cmd[0]), .io_write_op(cmd[1]), .data_space_sel(cmd[9]),
		.io_bit_set_op(cmd[2]), .io_bit_clear_op(cmd[3]), .skip_if_io_bit_set(cmd[4]),
		.skip_if_io_bit_clear(cmd[5]), .bit_sel(io_wdata[2:0]), .bit_to_copy_flag(cmd[6]),
		.copy_flag_to_bit(cmd[7]), .reg_src(data_addr[7:0]), .alu_flags_we(cmd[8]), .alu_flags_mask(io_wdata[4:0]),
		.alu_half(data_addr[4]), .alu_ovf(data_addr[3]), .alu_neg(data_addr[2]), .alu_zero(data_addr[1]),
		.alu_carry(data_addr[0]), .stack_op(cmd[12:10]));
	ssr_periph_model u_ssr_periph_model (.*, .rd_addr(cmd[9] ? data_addr[5:0] - 6'h20 : io_addr));
	// One request cycle, then idle; outputs are looked at just after the taking edge
	task automatic op(input logic [12:0] c, input logic [10:0] a, input logic [7:0] d);
		@(posedge clock);
		cmd <= c;
		io_addr <= a[5:0];
		data_addr <= a;
		io_wdata <= d;
		@(posedge clock);
		cmd <= '0;
		#1;
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_regs;
		chk("reset", {status_flags_reg, stack_ptr[7:0]}, 16'h0000);
		op(13'h0002, 11'h03D, 8'h55);
		chk("sp", stack_ptr, 16'h0055);
		op(13'h0002, 11'h03E, 8'hFF);
		chk("sp", stack_ptr, 16'h0755);
		op(13'h0001, 11'h03E, 8'h00);
		chk("sph", io_rdata, 16'h0007);
		op(13'h0002, 11'h00C, 8'h3C);
		chk("ewr", {ext_write, ext_addr, ext_wdata}, {1'b1, 6'h0C, 8'h3C});
		op(13'h0201, 11'h02C, 8'h00);
		chk("per", io_rdata, 16'h003C);
		op(13'h0201, 11'h05D, 8'h00);
		chk("spl", io_rdata, 16'h0055);
		op(13'h0202, 11'h060, 8'hAA);
		chk("refuse", {access_err, ext_write}, 16'h0002);
		$display("regs done");
	endtask
	task automatic t_stack;
		logic [2:0]  ops [6] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5, 3'h6};
		int          dl [6] = '{-1, -2, 1, 2, -2, 2};
		logic [10:0] e;
		op(13'h0002, 11'h03E, 8'h04);
		op(13'h0002, 11'h03D, 8'h5F);
		e = 11'h45F;
		for (int i = 0; i < 6; i++) begin
			op({ops[i], 10'h000}, 11'h000, 8'h00);
			e = e + 11'(dl[i]);
			chk("sp", stack_ptr, e);
			if (ops[i] == 3'h1 || ops[i] == 3'h2)
				chk("addr", stack_addr, ops[i] == 3'h1 ? e + 11'h001 : e);
		end
		op(13'h0002, 11'h03E, 8'h01);
		op(13'h0002, 11'h03D, 8'h00);
		op(13'h0400, 11'h000, 8'h00);
		chk("wrap", stack_ptr, 16'h00FF);
		$display("stack done");
	endtask
	task automatic t_flags;
		op(13'h0202, 11'h05F, 8'h84);
		chk("status", status_flags_reg, 16'h0094);
		@(posedge clock);
		irq_pending <= 17'h10000;
		irq_enable <= 17'h10000;
		@(posedge clock);
		#1;
		chk("irq", irq_request, 16'h0001);
		op(13'h1400, 11'h000, 8'h00);
		chk("entry", {irq_request, status_flags_reg}, 16'h0014);
		op(13'h1800, 11'h000, 8'h00);
		chk("return", {irq_request, status_flags_reg}, 16'h0194);
		@(posedge clock);
		irq_enable <= 17'h00000;
		@(posedge clock);
		#1;
		chk("irq", irq_request, 16'h0000);
		op(13'h0100, 11'h01B, 8'h1F);
		chk("alu", status_flags_reg, 16'h00BB);
		op(13'h0100, 11'h000, 8'h01);
		chk("alu", status_flags_reg, 16'h00BA);
		op(13'h0040, 11'h008, 8'h03);
		chk("copy", status_flags_reg, 16'h00FA);
		op(13'h0080, 11'h000, 8'h05);
		chk("load", reg_result, 16'h0020);
		$display("flags done");
	endtask
	task automatic t_bits;
		op(13'h0004, 11'h00B, 8'h00);
		chk("bset", {ext_write, ext_addr, ext_wdata}, {1'b1, 6'h0B, 8'hAF});
		op(13'h0010, 11'h00B, 8'h01);
		chk("skip", skip_next, 16'h0001);
		op(13'h0020, 11'h00B, 8'h01);
		chk("skip", skip_next, 16'h0000);
		op(13'h0008, 11'h00B, 8'h07);
		chk("bclr", ext_wdata, 16'h002F);
		op(13'h0004, 11'h03F, 8'h00);
		chk("high", {access_err, status_flags_reg}, {1'b1, 8'hFA});
		$display("bits done");
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		t_regs;
		t_stack;
		t_flags;
		t_bits;
		final_report;
	end
	// About 80 cycles of tests; fifty times that is a hang
	initial begin
		#20000;
		mismatches++;
		final_report;
	end
endmodule // status_and_stack_regs_tb
